/* shared/sim_regs.svh */
`ifndef SIM_REGS_SVH
`define SIM_REGS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SIM_CSR_ADDR    4'h0
`define SIM_CSR_RESET   8'h00

// ----------------------------------------------------------------------
// field positions of integrity_control_status
// ----------------------------------------------------------------------
`define SIM_BIT_SRC_SEL 7
`define SIM_BIT_AVD_IE  6
`define SIM_BIT_AVD_FLG 5
`define SIM_BIT_UV_RF   4
`define SIM_BIT_CSS_IE  2
`define SIM_BIT_CSS_FD  1
`define SIM_BIT_WDG_RF  0

// ----------------------------------------------------------------------
// reset delay, in cpu cycles
// ----------------------------------------------------------------------
`define SIM_DLY_SHORT_CYC 13'h0100
`define SIM_DLY_LONG_CYC  13'h1000
`define SIM_DLY_SHORT_LD  12'(`SIM_DLY_SHORT_CYC - 13'h0001)
`define SIM_DLY_LONG_LD   12'(`SIM_DLY_LONG_CYC - 13'h0001)

`endif

/* shared/sim_pkg.sv */
package sim_pkg;

   // css path; gray along main -> safe, off entered from either
   typedef enum logic [1:0] {
      CSS_MAIN = 2'b00,
      CSS_SAFE = 2'b01,
      CSS_OFF  = 2'b11
   } sim_css_state_t;

   typedef struct packed {
      logic src_sel;
      logic avd_ie;
      logic avd_flag;
      logic uv_rst_flag;
      logic rsvd;
      logic css_ie;
      logic css_fail;
      logic wdg_rst_flag;
   } sim_csr_t;

   typedef struct packed {
      logic lvd_below;
      logic avd_below;
      logic clk_loss;
   } sim_analog_t;

   typedef struct packed {
      logic       lvd_en;
      logic [1:0] lvd_level;
      logic       pll_en;
      logic       css_en;
      logic       long_delay;
   } sim_option_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sim_bus_req_t;

   typedef struct packed {
      sim_analog_t stage1;
      sim_analog_t stage2;
   } sim_sync_state_t;

   typedef struct packed {
      logic [11:0] count;
      logic        busy;
   } sim_delay_state_t;

   typedef struct packed {
      sim_csr_t       csr;
      logic           avd_flag_seen;
      logic           avd_pend;
      logic           css_pend;
      sim_css_state_t css_state;
      logic [7:0]     rdata;
      logic           avd_irq;
      logic           css_irq;
      logic           wake;
      logic           pin_level;
      logic           pin_oe;
      logic           core_reset;
      logic [1:0]     lvd_thr;
      logic           filter_en;
      logic           safe_osc_en;
      logic           clk_sel_safe;
   } sim_state_t;

endpackage

/* rtl/sim_sync2.sv */
`timescale 1ns/100ps

module sim_sync2 (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire sim_pkg::sim_analog_t async_in,
   output      sim_pkg::sim_analog_t sync_out
);

   sim_pkg::sim_sync_state_t s_reg;
   sim_pkg::sim_sync_state_t s_next;

   // stage1 is only ever read by stage2
   always_comb begin
      s_next        = s_reg;
      s_next.stage1 = async_in;
      s_next.stage2 = s_reg.stage1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.stage2;

endmodule // sim_sync2

/* rtl/sim_rst_delay.sv */
`timescale 1ns/100ps
`include "sim_regs.svh"

module sim_rst_delay (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic hold,
   input  wire logic long_sel,
   output      logic busy
);

   sim_pkg::sim_delay_state_t s_reg;
   sim_pkg::sim_delay_state_t s_next;

   // reload while the source holds; busy stays up for the whole count
   always_comb begin
      s_next = s_reg;
      if (hold) begin
         s_next.count = long_sel ? `SIM_DLY_LONG_LD : `SIM_DLY_SHORT_LD;
         s_next.busy  = 1'b1;
      end else if (s_reg.count != 12'h000) begin
         s_next.count = s_reg.count - 12'h001;
         s_next.busy  = 1'b1;
      end else begin
         s_next.busy  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign busy = s_reg.busy;

endmodule // sim_rst_delay

/* rtl/sim_top.sv */
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "sim_regs.svh"

//
// What this block does
// RULE1 - undervoltage holds device and reset pin low
// RULE2 - option selects low, medium, high threshold
// RULE3 - option enables the undervoltage reset
// RULE4 - aux detector works only with undervoltage enabled
// RULE5 - aux flag mirrors comparator, read only
// RULE6 - source select: supply or external pin
// RULE7 - flag toggle raises interrupt when enabled
// RULE8 - interrupt service entry clears aux pending
// RULE9 - no aux interrupt during reset delay
// RULE10 - enabling while undervoltage interrupts at once
// RULE11 - spike filter only with pll enabled
// RULE12 - lost main clock selects safe oscillator
// RULE13 - recovered main clock switches back automatically
// RULE14 - safe clock sets failure flag, interrupt
// RULE15 - interrupt needs enable and cleared mask
// RULE16 - wait mode unchanged, interrupts wake
// RULE17 - halt freezes register, disables clock guard
// RULE18 - halt exit resumes config, reset restores
// RULE19 - failure flag cleared by read after recovery
// RULE20 - clock guard enable gates failure interrupt
// RULE21 - undervoltage flag cleared only by writing zero
// RULE22 - watchdog flag cleared by zero or undervoltage
// RULE23 - analog indications synchronised before use
module sim_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire sim_pkg::sim_bus_req_t bus_req,
   output      logic [7:0]           reg_rdata,
   input  wire sim_pkg::sim_option_t  opt,
   input  wire sim_pkg::sim_analog_t  analog_in,
   input  wire logic                 wdg_reset,
   input  wire logic                 rst_pin_i,
   output      logic                 rst_pin_o,
   output      logic                 rst_pin_oe,
   output      logic                 core_reset,
   output      logic [1:0]           lvd_threshold_sel,
   output      logic                 monitor_source_select,
   output      logic                 spike_filter_en,
   output      logic                 safe_osc_en,
   output      logic                 cpu_clk_sel_safe,
   input  wire logic                 cpu_int_mask,
   input  wire logic                 avd_isr_ack,
   input  wire logic                 css_isr_ack,
   input  wire logic                 wait_mode,
   input  wire logic                 halt_mode,
   output      logic                 avd_irq,
   output      logic                 css_irq,
   output      logic                 wait_wake
);

   // ----------------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------------
   sim_pkg::sim_state_t  s_reg;
   sim_pkg::sim_state_t  s_next;
   sim_pkg::sim_analog_t syn;
   logic                 dly_busy;
   logic                 dly_hold;
   logic                 lvd_active;
   logic                 avd_active;
   logic                 in_reset;
   logic                 hit;
   logic                 wr_ok;
   logic                 rd_ok;
   logic                 avd_set;
   logic                 css_run;

   // ----------------------------------------------------------------------
   // synchroniser and reset delay
   // ----------------------------------------------------------------------
   // comparators and clock-loss detector are asynchronous
   sim_sync2 u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (analog_in),
      .sync_out (syn)
   ); // RULE23

   // external pull-down seen only while we are not driving the pin
   assign dly_hold = lvd_active | wdg_reset | (~rst_pin_i & ~s_reg.pin_oe);

   sim_rst_delay u_delay (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .hold     (dly_hold),
      .long_sel (opt.long_delay),
      .busy     (dly_busy)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_next     = s_reg;
      lvd_active = opt.lvd_en & syn.lvd_below; // RULE1 RULE3
      avd_active = opt.lvd_en; // RULE4
      in_reset   = lvd_active | dly_busy;
      css_run    = opt.css_en & ~halt_mode; // RULE17
      hit        = (bus_req.addr == `SIM_CSR_ADDR);
      // register frozen in halt, and the cpu cannot write while in reset
      wr_ok      = bus_req.wr & hit & ~halt_mode & ~in_reset; // RULE17
      rd_ok      = bus_req.rd & hit;

      // reset pin and core reset through active and delay phases
      s_next.pin_level  = 1'b0;
      s_next.pin_oe     = in_reset; // RULE1
      s_next.core_reset = in_reset; // RULE1
      s_next.lvd_thr    = opt.lvd_level; // RULE2
      s_next.filter_en  = opt.pll_en; // RULE11

      // control bits; any device reset brings back reset values
      if (in_reset) begin
         s_next.csr.src_sel = 1'b0; // RULE18
         s_next.csr.avd_ie  = 1'b0;
         s_next.csr.css_ie  = 1'b0;
      end else if (wr_ok) begin
         s_next.csr.src_sel = bus_req.wdata[`SIM_BIT_SRC_SEL]; // RULE6
         s_next.csr.avd_ie  = bus_req.wdata[`SIM_BIT_AVD_IE];
         s_next.csr.css_ie  = bus_req.wdata[`SIM_BIT_CSS_IE]; // RULE20
      end
      s_next.csr.rsvd = 1'b0;

      // reset-source flags survive external and watchdog resets
      if (lvd_active) begin
         s_next.csr.uv_rst_flag = 1'b1; // RULE21
      end else if (wr_ok && !bus_req.wdata[`SIM_BIT_UV_RF]) begin
         s_next.csr.uv_rst_flag = 1'b0; // RULE21
      end
      if (lvd_active) begin
         s_next.csr.wdg_rst_flag = 1'b0; // RULE22
      end else if (wdg_reset) begin
         s_next.csr.wdg_rst_flag = 1'b1; // RULE22
      end else if (wr_ok && !bus_req.wdata[`SIM_BIT_WDG_RF]) begin
         s_next.csr.wdg_rst_flag = 1'b0; // RULE22
      end

      // aux flag follows the comparator in real time unless frozen
      if (!halt_mode) begin
         s_next.csr.avd_flag  = avd_active & syn.avd_below; // RULE5
         s_next.avd_flag_seen = s_reg.csr.avd_flag;
      end

      // toggles during reset or delay are absorbed by avd_flag_seen
      avd_set = avd_active & ~halt_mode & ~in_reset &
                ((s_reg.csr.avd_ie & (s_reg.csr.avd_flag != s_reg.avd_flag_seen)) |
                 (wr_ok & bus_req.wdata[`SIM_BIT_AVD_IE] & ~s_reg.csr.avd_ie &
                  s_reg.csr.avd_flag)); // RULE7 RULE9 RULE10
      // set wins over the service-entry clear
      if (avd_set) begin
         s_next.avd_pend = 1'b1; // RULE7
      end else if (avd_isr_ack || in_reset || !avd_active) begin
         s_next.avd_pend = 1'b0; // RULE8
      end

      // clock guard path
      unique case (s_reg.css_state)
         sim_pkg::CSS_MAIN: begin
            if (!css_run) begin
               s_next.css_state = sim_pkg::CSS_OFF;
            end else if (syn.clk_loss) begin
               s_next.css_state = sim_pkg::CSS_SAFE; // RULE12
            end
         end
         sim_pkg::CSS_SAFE: begin
            if (!css_run) begin
               s_next.css_state = sim_pkg::CSS_OFF;
            end else if (!syn.clk_loss) begin
               s_next.css_state = sim_pkg::CSS_MAIN; // RULE13
            end
         end
         sim_pkg::CSS_OFF: begin
            // a clock already lost on leaving halt goes straight to safe
            if (css_run && syn.clk_loss) begin
               s_next.css_state = sim_pkg::CSS_SAFE; // RULE12
            end else if (css_run) begin
               s_next.css_state = sim_pkg::CSS_MAIN; // RULE18
            end
         end
         default: begin
            s_next.css_state = sim_pkg::CSS_OFF;
         end
      endcase
      s_next.clk_sel_safe = (s_next.css_state == sim_pkg::CSS_SAFE);
      s_next.safe_osc_en  = (s_next.css_state != sim_pkg::CSS_OFF); // RULE17

      // failure flag: set while on safe clock, read clears once recovered
      if (!opt.css_en) begin
         s_next.csr.css_fail = 1'b0; // RULE19
      end else if (halt_mode) begin
         s_next.csr.css_fail = s_reg.csr.css_fail;
      end else if (s_next.css_state == sim_pkg::CSS_SAFE) begin
         s_next.csr.css_fail = 1'b1; // RULE14
      end else if (rd_ok && s_reg.css_state == sim_pkg::CSS_MAIN) begin
         s_next.csr.css_fail = 1'b0; // RULE19
      end

      // enable must already be set when the switch happens
      if (s_next.clk_sel_safe && !s_reg.clk_sel_safe && s_reg.csr.css_ie) begin
         s_next.css_pend = 1'b1; // RULE14
      end else if (css_isr_ack || in_reset || !opt.css_en) begin
         s_next.css_pend = 1'b0; // RULE20
      end

      s_next.avd_irq = s_reg.avd_pend & s_reg.csr.avd_ie & ~cpu_int_mask; // RULE15
      s_next.css_irq = s_reg.css_pend & s_reg.csr.css_ie & opt.css_en &
                       ~cpu_int_mask; // RULE15 RULE20
      // these events never leave halt, only wait
      s_next.wake = wait_mode & ~halt_mode & (s_next.avd_irq | s_next.css_irq); // RULE16

      s_next.rdata = rd_ok ? s_reg.csr : 8'h00;
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata             = s_reg.rdata;
   assign rst_pin_o             = s_reg.pin_level;
   assign rst_pin_oe            = s_reg.pin_oe;
   assign core_reset            = s_reg.core_reset;
   assign lvd_threshold_sel     = s_reg.lvd_thr;
   assign monitor_source_select = s_reg.csr.src_sel;
   assign spike_filter_en       = s_reg.filter_en;
   assign safe_osc_en           = s_reg.safe_osc_en;
   assign cpu_clk_sel_safe      = s_reg.clk_sel_safe;
   assign avd_irq               = s_reg.avd_irq;
   assign css_irq               = s_reg.css_irq;
   assign wait_wake             = s_reg.wake;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence uv_seen_s;
      opt.lvd_en && syn.lvd_below;
   endsequence

   sequence uv_reset_s;
      rst_pin_oe && core_reset && !rst_pin_o;
   endsequence

   uv_holds_reset_a: assert property (uv_seen_s |=> uv_reset_s) // RULE1
      else $error("undervoltage did not hold reset");

   uv_flag_set_a: assert property (uv_seen_s |=>
         s_reg.csr.uv_rst_flag && !s_reg.csr.wdg_rst_flag) // RULE21
      else $error("undervoltage flags wrong");

   delay_no_avd_a: assert property (dly_busy |=> !$rose(s_reg.avd_pend)) // RULE9
      else $error("aux interrupt during reset delay");

   avd_toggle_pend_a: assert property (avd_active && !in_reset && !halt_mode &&
         s_reg.csr.avd_ie && (s_reg.csr.avd_flag != s_reg.avd_flag_seen)
         |=> s_reg.avd_pend) // RULE7
      else $error("aux toggle lost");

   avd_enable_pend_a: assert property (wr_ok && avd_active && !in_reset &&
         bus_req.wdata[`SIM_BIT_AVD_IE] && !s_reg.csr.avd_ie &&
         s_reg.csr.avd_flag |=> s_reg.avd_pend ##1 (avd_irq || $past(cpu_int_mask))) // RULE10
      else $error("enable during undervoltage gave no interrupt");

   avd_ack_clear_a: assert property (avd_isr_ack && !avd_set |=> !s_reg.avd_pend) // RULE8
      else $error("service entry did not clear aux pending");

   irq_gate_a: assert property ((avd_irq || css_irq) |-> !$past(cpu_int_mask)) // RULE15
      else $error("interrupt while masked");

   safe_switch_a: assert property (css_run && syn.clk_loss |=>
         cpu_clk_sel_safe && s_reg.csr.css_fail) // RULE12 RULE14
      else $error("no switch to safe clock");

   switch_back_a: assert property (css_run && !syn.clk_loss |=> !cpu_clk_sel_safe) // RULE13
      else $error("no switch back to main clock");

   halt_guard_off_a: assert property (halt_mode |=> !safe_osc_en && !cpu_clk_sel_safe) // RULE17
      else $error("clock guard active in halt");

   halt_freeze_a: assert property (halt_mode && !in_reset |=>
         $stable(s_reg.csr.src_sel) && $stable(s_reg.csr.avd_ie) &&
         $stable(s_reg.csr.css_ie)) // RULE17
      else $error("register changed in halt");

   fail_read_clear_a: assert property (rd_ok && opt.css_en && !halt_mode &&
         s_reg.css_state == sim_pkg::CSS_MAIN && !syn.clk_loss
         |=> !s_reg.csr.css_fail) // RULE19
      else $error("failure flag not cleared by read");

   css_off_flag_a: assert property (!opt.css_en |=> !s_reg.csr.css_fail ##1 !css_irq) // RULE19 RULE20
      else $error("clock guard bits live while disabled");

   wait_wake_a: assert property (wait_wake |-> (avd_irq || css_irq) && $past(wait_mode)) // RULE16
      else $error("wake without interrupt");

endmodule // sim_top

/* bench/tb_system_integrity_monitor.sv */
`timescale 1ns/100ps
`include "sim_regs.svh"

module tb_system_integrity_monitor;

   // ----------------------------------------------------------------------
   // clock, reset and design connections
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } sim_row_t;

   logic                  ref_clk = 1'b0;
   logic                  rst     = 1'b1;
   sim_pkg::sim_bus_req_t bus_req = '0;
   sim_pkg::sim_option_t  opt     = '{1'b1, 2'b10, 1'b1, 1'b1, 1'b0};
   sim_pkg::sim_analog_t  analog_in = '0;
   logic                  wdg_reset = 1'b0;
   logic                  cpu_int_mask = 1'b0;
   logic                  avd_isr_ack = 1'b0;
   logic                  css_isr_ack = 1'b0;
   logic                  wait_mode = 1'b0;
   logic                  halt_mode = 1'b0;
   logic [7:0]            reg_rdata;
   logic                  rst_pin_i;
   logic                  rst_pin_o;
   logic                  rst_pin_oe;
   logic                  core_reset;
   logic [1:0]            lvd_threshold_sel;
   logic                  monitor_source_select;
   logic                  spike_filter_en;
   logic                  safe_osc_en;
   logic                  cpu_clk_sel_safe;
   logic                  avd_irq;
   logic                  css_irq;
   logic                  wait_wake;
   logic [4:0]            mon;
   logic [7:0]            rd;
   int                    n_fail = 0;
   int                    n_compared = 0;
   int                    cyc = 0;
   sim_row_t              rows [5];

   always #25 ref_clk = ~ref_clk;

   // open-drain pin with a pull-up: released means high
   assign rst_pin_i = rst_pin_oe ? rst_pin_o : 1'b1;
   assign mon = {wait_wake, core_reset, cpu_clk_sel_safe, css_irq, avd_irq};

   sim_top i_sim_top (
      .ref_clk               (ref_clk),
      .rst                   (rst),
      .bus_req               (bus_req),
      .reg_rdata             (reg_rdata),
      .opt                   (opt),
      .analog_in             (analog_in),
      .wdg_reset             (wdg_reset),
      .rst_pin_i             (rst_pin_i),
      .rst_pin_o             (rst_pin_o),
      .rst_pin_oe            (rst_pin_oe),
      .core_reset            (core_reset),
      .lvd_threshold_sel     (lvd_threshold_sel),
      .monitor_source_select (monitor_source_select),
      .spike_filter_en       (spike_filter_en),
      .safe_osc_en           (safe_osc_en),
      .cpu_clk_sel_safe      (cpu_clk_sel_safe),
      .cpu_int_mask          (cpu_int_mask),
      .avd_isr_ack           (avd_isr_ack),
      .css_isr_ack           (css_isr_ack),
      .wait_mode             (wait_mode),
      .halt_mode             (halt_mode),
      .avd_irq               (avd_irq),
      .css_irq               (css_irq),
      .wait_wake             (wait_wake)
   );

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask

   // read data stand only in the cycle after the strobe
   task reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      d = reg_rdata;
   endtask

   task rd_chk(input logic [7:0] exp);
      reg_rd(`SIM_CSR_ADDR, rd);
      check("csr", rd, exp);
   endtask

   task wait_bit(input int idx, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge ref_clk);
         #1;
         if (mon[idx] === v) break;
      end
      check("mon bit", {7'h00, mon[idx]}, {7'h00, v});
   endtask

   task pulse_ack(input logic clock_guard);
      @(posedge ref_clk);
      if (clock_guard) css_isr_ack <= 1'b1; else avd_isr_ack <= 1'b1;
      @(posedge ref_clk);
      css_isr_ack <= 1'b0;
      avd_isr_ack <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   // short reset delay plus sync stages; generous to absorb both
   task wait_out_of_reset;
      wait_bit(3, 1'b0, 300);
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rows[0] = '{4'h0, 8'hFF, 8'hC4};
      rows[1] = '{4'h0, 8'h00, 8'h00};
      rows[2] = '{4'h0, 8'h40, 8'h40};
      rows[3] = '{4'h5, 8'hFF, 8'h40};
      rows[4] = '{4'h0, 8'h84, 8'h84};
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      check("core_reset", {7'h00, core_reset}, 8'h00);
      check("threshold", {6'h00, lvd_threshold_sel}, 8'h02);
      check("filter", {7'h00, spike_filter_en}, 8'h01);
      rd_chk(8'h00);
      reg_rd(4'h7, rd);
      check("unmapped", rd, 8'h00);
      foreach (rows[i]) begin
         reg_wr(rows[i].addr, rows[i].wdata);
         rd_chk(rows[i].exp);
      end
      check("src", {7'h00, monitor_source_select}, 8'h01);
      // aux toggle both ways, mask, wait wake
      reg_wr(4'h0, 8'h40);
      @(posedge ref_clk);
      wait_mode <= 1'b1;
      analog_in.avd_below <= 1'b1;
      wait_bit(0, 1'b1, 10);
      wait_bit(4, 1'b1, 3);
      rd_chk(8'h60);
      pulse_ack(1'b0);
      #1;
      check("avd_irq", {7'h00, avd_irq}, 8'h00);
      @(posedge ref_clk);
      cpu_int_mask <= 1'b1;
      analog_in.avd_below <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      check("masked", {7'h00, avd_irq}, 8'h00);
      @(posedge ref_clk);
      cpu_int_mask <= 1'b0;
      wait_bit(0, 1'b1, 4);
      pulse_ack(1'b0);
      wait_mode <= 1'b0;
      // enabling while under threshold, then the rise
      reg_wr(4'h0, 8'h00);
      @(posedge ref_clk);
      analog_in.avd_below <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      check("disabled", {7'h00, avd_irq}, 8'h00);
      reg_wr(4'h0, 8'h40);
      wait_bit(0, 1'b1, 5);
      pulse_ack(1'b0);
      analog_in.avd_below <= 1'b0;
      wait_bit(0, 1'b1, 8);
      pulse_ack(1'b0);
      // clock loss with and without interrupt enable
      reg_wr(4'h0, 8'h04);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b1;
      wait_bit(2, 1'b1, 8);
      check("safe osc", {7'h00, safe_osc_en}, 8'h01);
      wait_bit(1, 1'b1, 3);
      rd_chk(8'h06);
      rd_chk(8'h06);
      pulse_ack(1'b1);
      analog_in.clk_loss <= 1'b0;
      wait_bit(2, 1'b0, 8);
      rd_chk(8'h06);
      rd_chk(8'h04);
      reg_wr(4'h0, 8'h00);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b1;
      wait_bit(2, 1'b1, 8);
      repeat (6) @(posedge ref_clk);
      #1;
      check("css_irq", {7'h00, css_irq}, 8'h00);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b0;
      wait_bit(2, 1'b0, 8);
      rd_chk(8'h02);
      rd_chk(8'h00);
      // halt freezes the register and stops the clock guard
      reg_wr(4'h0, 8'h80);
      @(posedge ref_clk);
      halt_mode <= 1'b1;
      analog_in.clk_loss <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      check("halt osc", {7'h00, safe_osc_en}, 8'h00);
      check("halt sel", {7'h00, cpu_clk_sel_safe}, 8'h00);
      reg_wr(4'h0, 8'h00);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b0;
      repeat (4) @(posedge ref_clk);
      halt_mode <= 1'b0;
      rd_chk(8'h80);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b1;
      wait_bit(2, 1'b1, 8);
      @(posedge ref_clk);
      analog_in.clk_loss <= 1'b0;
      wait_bit(2, 1'b0, 8);
      rd_chk(8'h82);
      // watchdog and undervoltage resets, reset flags
      @(posedge ref_clk);
      wdg_reset <= 1'b1;
      @(posedge ref_clk);
      wdg_reset <= 1'b0;
      wait_bit(3, 1'b1, 6);
      wait_out_of_reset();
      rd_chk(8'h01);
      @(posedge ref_clk);
      analog_in.lvd_below <= 1'b1;
      wait_bit(3, 1'b1, 6);
      repeat (20) @(posedge ref_clk);
      #1;
      check("pin oe", {7'h00, rst_pin_oe}, 8'h01);
      check("pin level", {7'h00, rst_pin_i}, 8'h00);
      @(posedge ref_clk);
      analog_in.lvd_below <= 1'b0;
      wait_out_of_reset();
      rd_chk(8'h10);
      @(posedge ref_clk);
      wdg_reset <= 1'b1;
      @(posedge ref_clk);
      wdg_reset <= 1'b0;
      wait_bit(3, 1'b1, 6);
      wait_out_of_reset();
      rd_chk(8'h11);
      reg_wr(4'h0, 8'h01);
      rd_chk(8'h01);
      reg_wr(4'h0, 8'h00);
      rd_chk(8'h00);
      // undervoltage function switched off by option
      @(posedge ref_clk);
      opt.lvd_en <= 1'b0;
      analog_in.lvd_below <= 1'b1;
      repeat (10) @(posedge ref_clk);
      #1;
      check("no lvd", {7'h00, core_reset}, 8'h00);
      reg_wr(4'h0, 8'h40);
      @(posedge ref_clk);
      analog_in.avd_below <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      check("no avd irq", {7'h00, avd_irq}, 8'h00);
      reg_rd(`SIM_CSR_ADDR, rd);
      check("no avd flag", rd & 8'h20, 8'h00);
      // clock guard and pll filter switched off by option
      @(posedge ref_clk);
      opt.css_en <= 1'b0;
      opt.pll_en <= 1'b0;
      analog_in.clk_loss <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      check("no css", {6'h00, safe_osc_en, cpu_clk_sel_safe}, 8'h00);
      check("no filter", {7'h00, spike_filter_en}, 8'h00);
      check("no css irq", {7'h00, css_irq}, 8'h00);
      reg_rd(`SIM_CSR_ADDR, rd);
      check("no fail flag", rd & 8'h02, 8'h00);
      give_verdict();
   end

endmodule // tb_system_integrity_monitor
